// file: common/system_tools_defines.svh
// register offsets, field positions and timing counts for system tools
// Notes on behaviour
// - command bits self-clear when their function finishes
// - bit 7 soft reset, busy about 60 ms
// - bit3 flash backup, bit1 restore, bit0 autonull
// - bit 8 clears capture buffers
// - line owner: misc, then alarm, then io
// - io bits 3..0 set line direction
// - io bits 11..8 drive or read levels
// - line one defaults to active-high data ready
// - misc bits 2..0: ready enable, polarity, line
// - misc bit 10 self-test, flags, self-clears
// - misc bit 11 checksum, result diag bit 6
// - diagnostic read clears all flags
// - persisting fault resets flag next sample
// - diag 15..10 accel and gyro self-test fails
// - diag bits 9,8 alarm two and one
// - diag 5,4,3,2 selftest, overrange, link, flash
// - 16-bit flash write counter, readable
// - id and serial registers read fixed values
// - misc bits 7,6 enable compensation options
// - restore zeroes calibration, flash within 50 ms
// - autonull negates gyro into offset, backs up
`ifndef SYSTEM_TOOLS_DEFINES_SVH
`define SYSTEM_TOOLS_DEFINES_SVH
`define ADDR_FLASH_COUNT 7'h00
`define ADDR_GENERAL_IO 7'h32
`define ADDR_MISC_CONTROL 7'h34
`define ADDR_DIAGNOSTIC 7'h3C
`define ADDR_GLOBAL_COMMAND 7'h3E
`define ADDR_LOT_LOW 7'h52
`define ADDR_LOT_HIGH 7'h54
`define ADDR_PRODUCT 7'h56
`define ADDR_SERIAL 7'h58
`define MISC_RESET 16'h0006
`define MISC_WRITE_MASK 16'h0CC7
`define IO_WRITE_MASK 16'h0F0F
`define CMD_SOFT_RESET 7
`define CMD_BACKUP 3
`define CMD_RESTORE 1
`define CMD_AUTONULL 0
`define CMD_CLEAR_BUFFERS 8
`define MISC_MEM_TEST 11
`define MISC_SELF_TEST 10
`define MISC_READY_EN 2
`define MISC_READY_POL 1
`define MISC_READY_LINE 0
`define MISC_GYRO_COMP 7
`define MISC_ACCEL_ALIGN 6
`define ALARM_IND_EN 2
`define ALARM_IND_POL 1
`define ALARM_IND_LINE 0
`define DIAG_CHECKSUM 6
`define DIAG_SELFTEST_MASK 16'hFC20
`define DIAG_FLAG_MASK 16'hFF7C
`define CLOCK_NS 100
`define SOFT_RESET_MS 60
`define RESTORE_MS 50
`define SOFT_RESET_CYCLES ((`SOFT_RESET_MS * 1000000) / `CLOCK_NS)
`define RESTORE_CYCLES ((`RESTORE_MS * 1000000) / `CLOCK_NS)
`define SHORT_CMD_CYCLES 16
`endif

// file: common/system_tools_pkg.sv
// types shared by the system tools register bank
package system_tools_pkg;
	typedef enum logic [2:0] {
		idle_st = 3'b000,
		reset_st = 3'b001,
		backup_st = 3'b010,
		restore_st = 3'b011,
		autonull_st = 3'b100,
		buffers_st = 3'b101,
		test_st = 3'b110
	} busy_state_t;
	typedef struct packed {
		logic [2:0] accel_fail;
		logic [2:0] gyro_fail;
		logic [1:0] alarm;
		logic checksum_fail;
		logic selftest_error;
		logic overrange;
		logic link_fail;
		logic flash_fail;
	} fault_t;
	typedef struct packed {
		logic [6:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
endpackage

// file: design/system_tools_control_status.sv
// system tools register bank: commands, io lines, diagnostics, ids
`timescale 1ns/1ns
`include "system_tools_defines.svh"
module system_tools_control_status #(
	parameter int unsigned SOFT_RESET_COUNT = `SOFT_RESET_CYCLES,
	parameter int unsigned RESTORE_COUNT = `RESTORE_CYCLES,
	parameter logic [15:0] LOT_LOW_VALUE = 16'h1111, // arbitrary
	parameter logic [15:0] LOT_HIGH_VALUE = 16'h2222, // arbitrary
	parameter logic [15:0] PRODUCT_VALUE = 16'h1234, // arbitrary
	parameter logic [15:0] SERIAL_VALUE = 16'h0042 // arbitrary
) (
	input wire logic clock,
	input wire logic rst,
	input system_tools_pkg::reg_req_t req,
	output logic [15:0] rdata,
	output logic busy,
	input wire logic sample_tick,
	input wire logic data_fresh,
	input system_tools_pkg::fault_t fault_now,
	input wire logic [5:0] selftest_fail,
	input wire logic checksum_bad,
	input wire logic [7:0] alarm_control,
	input wire logic [1:0] alarm_active,
	input wire logic flash_write_done,
	input wire logic [3:0] aux_in,
	output logic [3:0] aux_out,
	output logic [3:0] aux_oe_n,
	output logic soft_reset_pulse,
	output logic backup_start,
	output logic restore_start,
	output logic autonull_start,
	output logic clear_buffers,
	output logic selftest_start,
	output logic memtest_start,
	output logic gyro_lin_comp,
	output logic accel_align
);
	system_tools_pkg::busy_state_t state;
	logic [31:0] timer;
	logic [15:0] io_ctrl;
	logic [15:0] misc;
	logic [15:0] diag;
	logic [15:0] flash_count;
	logic [3:0] aux_s1, aux_s2, aux_s3, aux_in_q;
	logic [3:0] next_out, next_oe_n;
	logic [15:0] next_rdata;
	logic [15:0] fault_bits;
	logic ready_level, alarm_level, diag_read, io_write, misc_write;
	logic cmd_write;

	function automatic logic [15:0] pack_faults(
		system_tools_pkg::fault_t f);
		pack_faults = {f.accel_fail, f.gyro_fail, f.alarm, 1'b0,
			f.checksum_fail, f.selftest_error, f.overrange,
			f.link_fail, f.flash_fail, 2'b00};
	endfunction

	assign diag_read = req.rd && (req.addr == `ADDR_DIAGNOSTIC);
	assign io_write = req.wr && (req.addr == `ADDR_GENERAL_IO);
	assign misc_write = req.wr && (req.addr == `ADDR_MISC_CONTROL);
	assign cmd_write = req.wr && (req.addr == `ADDR_GLOBAL_COMMAND)
		&& (state == system_tools_pkg::idle_st);

	// three-stage pin sync; a change counts once stages two and three agree
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			aux_s1 <= 4'h0;
			aux_s2 <= 4'h0;
			aux_s3 <= 4'h0;
			aux_in_q <= 4'h0;
		end else begin
			aux_s1 <= aux_in;
			aux_s2 <= aux_s1;
			aux_s3 <= aux_s2;
			for (int i = 0; i < 4; i++) begin
				if (aux_s2[i] == aux_s3[i]) begin
					aux_in_q[i] <= aux_s3[i];
				end
			end
		end
	end

	// command sequencer; command and misc control writes during a run are dropped, host must wait
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= system_tools_pkg::idle_st;
			timer <= 32'h0;
		end else begin
			case (state)
			system_tools_pkg::idle_st: begin
				timer <= 32'h0;
				if (cmd_write && req.wdata[`CMD_SOFT_RESET]) begin
					state <= system_tools_pkg::reset_st;
				end else if (cmd_write && req.wdata[`CMD_BACKUP]) begin
					state <= system_tools_pkg::backup_st;
				end else if (cmd_write && req.wdata[`CMD_RESTORE]) begin
					state <= system_tools_pkg::restore_st;
				end else if (cmd_write && req.wdata[`CMD_AUTONULL]) begin
					state <= system_tools_pkg::autonull_st;
				end else if (cmd_write && req.wdata[`CMD_CLEAR_BUFFERS]) begin
					state <= system_tools_pkg::buffers_st;
				end else if (misc_write && (req.wdata[`MISC_SELF_TEST]
					|| req.wdata[`MISC_MEM_TEST])) begin
					state <= system_tools_pkg::test_st;
				end
			end
			system_tools_pkg::reset_st: begin
				timer <= timer + 32'h1;
				if (timer >= SOFT_RESET_COUNT - 1) begin
					state <= system_tools_pkg::idle_st;
				end
			end
			system_tools_pkg::restore_st: begin
				timer <= timer + 32'h1;
				if (timer >= RESTORE_COUNT - 1) begin
					state <= system_tools_pkg::idle_st;
				end
			end
			system_tools_pkg::backup_st,
			system_tools_pkg::autonull_st,
			system_tools_pkg::buffers_st,
			system_tools_pkg::test_st: begin
				timer <= timer + 32'h1;
				if (timer >= `SHORT_CMD_CYCLES - 1) begin
					state <= system_tools_pkg::idle_st;
				end
			end
			default: state <= system_tools_pkg::idle_st;
			endcase
		end
	end

	// one-cycle start strobes toward the sensor core
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			soft_reset_pulse <= 1'b0;
			backup_start <= 1'b0;
			restore_start <= 1'b0;
			autonull_start <= 1'b0;
			clear_buffers <= 1'b0;
			selftest_start <= 1'b0;
			memtest_start <= 1'b0;
			busy <= 1'b0;
		end else begin
			soft_reset_pulse <= cmd_write && req.wdata[`CMD_SOFT_RESET];
			backup_start <= cmd_write && req.wdata[`CMD_BACKUP]
				&& !req.wdata[`CMD_SOFT_RESET];
			restore_start <= cmd_write && req.wdata[`CMD_RESTORE]
				&& !req.wdata[`CMD_SOFT_RESET]
				&& !req.wdata[`CMD_BACKUP];
			autonull_start <= cmd_write && req.wdata[`CMD_AUTONULL]
				&& (req.wdata[3:1] == 3'b000)
				&& !req.wdata[`CMD_SOFT_RESET];
			clear_buffers <= cmd_write && req.wdata[`CMD_CLEAR_BUFFERS]
				&& (req.wdata[7:0] == 8'h00);
			selftest_start <= misc_write && req.wdata[`MISC_SELF_TEST]
				&& (state == system_tools_pkg::idle_st);
			memtest_start <= misc_write && req.wdata[`MISC_MEM_TEST]
				&& (state == system_tools_pkg::idle_st);
			// a test run raises busy with its start, as commands do
			busy <= (state != system_tools_pkg::idle_st) || cmd_write
				|| (misc_write && (state == system_tools_pkg::idle_st)
				&& (req.wdata[`MISC_SELF_TEST] || req.wdata[`MISC_MEM_TEST]));
		end
	end

	// io control: levels of input lines come from the pins on read
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			io_ctrl <= 16'h0000;
		end else if (io_write) begin
			io_ctrl <= req.wdata & `IO_WRITE_MASK;
		end
	end

	// misc control; test bits hold until the run ends
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			misc <= `MISC_RESET;
		end else if (misc_write && state == system_tools_pkg::idle_st) begin
			misc <= req.wdata & `MISC_WRITE_MASK;
		end else if (state == system_tools_pkg::test_st
			&& timer >= `SHORT_CMD_CYCLES - 1) begin
			misc[`MISC_SELF_TEST] <= 1'b0;
			misc[`MISC_MEM_TEST] <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			gyro_lin_comp <= 1'b0;
			accel_align <= 1'b0;
		end else begin
			gyro_lin_comp <= misc[`MISC_GYRO_COMP];
			accel_align <= misc[`MISC_ACCEL_ALIGN];
		end
	end

	// diagnostic flags: read clears, faults set again on sample ticks;
	// a set in the read cycle wins so no event is lost
	always_comb begin
		fault_bits = pack_faults(fault_now);
		fault_bits[9:8] = fault_bits[9:8] | alarm_active;
		fault_bits[15:10] = fault_bits[15:10] | selftest_fail;
		fault_bits[`DIAG_CHECKSUM] = fault_bits[`DIAG_CHECKSUM]
			| checksum_bad;
		fault_bits = fault_bits & `DIAG_FLAG_MASK;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			diag <= 16'h0000;
		end else begin
			diag <= (diag_read ? 16'h0000 : diag)
				| (sample_tick ? fault_bits : 16'h0000);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			flash_count <= 16'h0000;
		end else if (flash_write_done) begin
			flash_count <= flash_count + 16'h0001;
		end
	end

	// line ownership: misc ready, then alarm indicator, then io control
	always_comb begin
		ready_level = misc[`MISC_READY_POL] ? data_fresh : !data_fresh;
		alarm_level = alarm_control[`ALARM_IND_POL] ? |alarm_active
			: !(|alarm_active);
		next_out = io_ctrl[11:8];
		next_oe_n = ~io_ctrl[3:0];
		if (alarm_control[`ALARM_IND_EN]) begin
			next_out[alarm_control[`ALARM_IND_LINE]] = alarm_level;
			next_oe_n[alarm_control[`ALARM_IND_LINE]] = 1'b0;
		end
		if (misc[`MISC_READY_EN]) begin
			next_out[misc[`MISC_READY_LINE]] = ready_level;
			next_oe_n[misc[`MISC_READY_LINE]] = 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			aux_out <= 4'h0;
			aux_oe_n <= 4'hF;
		end else begin
			aux_out <= next_out;
			aux_oe_n <= next_oe_n;
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		case (req.addr)
		`ADDR_FLASH_COUNT: next_rdata = flash_count;
		`ADDR_GENERAL_IO: next_rdata = {4'h0,
			(io_ctrl[11:8] & io_ctrl[3:0]) | (aux_in_q & ~io_ctrl[3:0]),
			4'h0, io_ctrl[3:0]};
		`ADDR_MISC_CONTROL: next_rdata = misc;
		`ADDR_DIAGNOSTIC: next_rdata = diag;
		`ADDR_GLOBAL_COMMAND: next_rdata = {7'h00,
			state == system_tools_pkg::buffers_st,
			state == system_tools_pkg::reset_st, 3'b000,
			state == system_tools_pkg::backup_st, 1'b0,
			state == system_tools_pkg::restore_st,
			state == system_tools_pkg::autonull_st};
		`ADDR_LOT_LOW: next_rdata = LOT_LOW_VALUE;
		`ADDR_LOT_HIGH: next_rdata = LOT_HIGH_VALUE;
		`ADDR_PRODUCT: next_rdata = PRODUCT_VALUE;
		`ADDR_SERIAL: next_rdata = SERIAL_VALUE;
		default: next_rdata = 16'h0000;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata <= 16'h0000;
		end else if (req.rd) begin
			rdata <= next_rdata;
		end
	end

	diag_read_clears_a: assert property (
		@(posedge clock) disable iff (rst)
		diag_read && !sample_tick |=> diag == 16'h0000)
		else $error("diagnostic flags not cleared by read");
	fault_reasserts_a: assert property (
		@(posedge clock) disable iff (rst)
		sample_tick |=> (diag & $past(fault_bits)) == $past(fault_bits))
		else $error("persisting fault not set again");
	reset_cmd_length_a: assert property (
		@(posedge clock) disable iff (rst)
		$rose(state == system_tools_pkg::reset_st) |->
		(state == system_tools_pkg::reset_st) [*8])
		else $error("soft reset ended too early");
	cmd_self_clears_a: assert property (
		@(posedge clock) disable iff (rst)
		state == system_tools_pkg::backup_st |-> ##[1:20]
		state == system_tools_pkg::idle_st)
		else $error("command bit did not self clear");
	backup_strobe_a: assert property (
		@(posedge clock) disable iff (rst)
		backup_start |-> state == system_tools_pkg::backup_st)
		else $error("backup strobe without backup run");
	ready_owns_line_a: assert property (
		@(posedge clock) disable iff (rst)
		misc[`MISC_READY_EN] |=> !aux_oe_n[$past(misc[`MISC_READY_LINE])])
		else $error("data ready line not driven");
	io_direction_a: assert property (
		@(posedge clock) disable iff (rst)
		!misc[`MISC_READY_EN] && !alarm_control[`ALARM_IND_EN]
		|=> aux_oe_n == ~$past(io_ctrl[3:0]))
		else $error("io direction not applied");
	flash_count_a: assert property (
		@(posedge clock) disable iff (rst)
		flash_write_done |=> flash_count == $past(flash_count) + 16'h1)
		else $error("flash counter did not step");
	selftest_clears_a: assert property (
		@(posedge clock) disable iff (rst)
		selftest_start |-> ##[1:20] !misc[`MISC_SELF_TEST])
		else $error("self-test bit did not clear");
	cmd_sets_busy_a: assert property (
		@(posedge clock) disable iff (rst)
		cmd_write |=> busy)
		else $error("busy not raised by command");
	test_sets_busy_a: assert property (
		@(posedge clock) disable iff (rst)
		selftest_start || memtest_start |-> busy)
		else $error("busy not raised by test run");
	clear_buffers_a: assert property (
		@(posedge clock) disable iff (rst)
		clear_buffers |-> state == system_tools_pkg::buffers_st)
		else $error("buffer clear strobe without run");
	autonull_strobe_a: assert property (
		@(posedge clock) disable iff (rst)
		autonull_start |-> state == system_tools_pkg::autonull_st)
		else $error("auto-null strobe without run");
	restore_length_a: assert property (
		@(posedge clock) disable iff (rst)
		$rose(state == system_tools_pkg::restore_st) |->
		(state == system_tools_pkg::restore_st) [*8])
		else $error("restore ended too early");
	memtest_clears_a: assert property (
		@(posedge clock) disable iff (rst)
		memtest_start |-> ##[1:20] !misc[`MISC_MEM_TEST])
		else $error("memory test bit did not clear");
	alarm_owns_line_a: assert property (
		@(posedge clock) disable iff (rst)
		alarm_control[`ALARM_IND_EN] && !misc[`MISC_READY_EN]
		|=> !aux_oe_n[$past(alarm_control[`ALARM_IND_LINE])])
		else $error("alarm indicator line not driven");
	soft_reset_c: cover property (@(posedge clock) soft_reset_pulse);
	diag_read_c: cover property (@(posedge clock)
		diag_read && diag != 16'h0000);
	selftest_c: cover property (@(posedge clock) selftest_start);
	ready_line_two_c: cover property (@(posedge clock)
		misc[`MISC_READY_EN] && misc[`MISC_READY_LINE]);
	alarm_line_c: cover property (@(posedge clock)
		alarm_control[`ALARM_IND_EN] && !misc[`MISC_READY_EN]);
endmodule // system_tools_control_status

// file: tb/host_model.sv
// host model issuing register requests to the system tools bank
`timescale 1ns/1ns
module host_model #(
	parameter int DLY = 10
) (
	input wire logic clock,
	input wire logic busy,
	output system_tools_pkg::reg_req_t req
);
	initial req = '0;
	task automatic access(input logic [6:0] addr, input logic [15:0] data,
		input logic wr);
		int n;
		n = 0;
		@(posedge clock);
		#DLY;
		// a command written during a run is dropped, so wait it out
		while (busy !== 1'b0 && n < 1000) begin
			@(posedge clock);
			#DLY;
			n++;
		end
		req.addr = addr;
		req.wdata = data;
		req.wr = wr;
		req.rd = ~wr;
		@(posedge clock);
		#DLY;
		req.wr = 1'b0;
		req.rd = 1'b0;
		// released lines show a changing pattern, not the last value
		req.addr = ~addr;
		req.wdata = ~data;
	endtask
endmodule // host_model

// file: tb/test_system_tools_control_status.sv
// self-checking bench for the system tools register bank
`timescale 1ns/1ns
module test_system_tools_control_status;
	localparam int DLY = 10;
	localparam logic [15:0] LOT_LO = 16'hA51C; // arbitrary
	localparam logic [15:0] LOT_HI = 16'h3C7E; // arbitrary
	localparam logic [15:0] PROD = 16'h5A0F; // arbitrary
	localparam logic [15:0] SER = 16'h0C33; // arbitrary
	logic clock = 1'b0;
	logic rst = 1'b1;
	system_tools_pkg::reg_req_t req;
	logic [15:0] rdata;
	logic busy;
	logic sample_tick = 1'b0;
	logic data_fresh = 1'b0;
	system_tools_pkg::fault_t fault_now = '0;
	logic [3:0] aux_in = 4'h0;
	logic flash_write_done = 1'b0;
	logic [5:0] selftest_fail = 6'h00;
	logic checksum_bad = 1'b0;
	logic [7:0] alarm_control = 8'h00;
	logic [1:0] alarm_active = 2'h0;
	logic [15:0] diag_exp;
	logic [3:0] aux_out;
	logic [3:0] aux_oe_n;
	wire logic [6:0] pulses;
	logic gyro_lin_comp;
	logic accel_align;
	int err_total = 0;
	int checks_done = 0;
	int seed = 22;
	logic [15:0] rnd;
	logic [15:0] exp_q[$];
	logic [15:0] mask_q[$];
	logic [15:0] m_exp;
	logic [15:0] m_mask;
	logic rd_seen = 1'b0;
	logic [6:0] addr_t[7] = '{7'h52, 7'h54, 7'h56, 7'h58, 7'h34, 7'h32, 7'h10};
	logic [15:0] val_t[7] = '{LOT_LO, LOT_HI, PROD, SER, 16'h0006, 16'h0000,
		16'h0000};
	int cmd_bit[4] = '{3, 1, 0, 8};
	int cmd_pulse[4] = '{5, 4, 3, 2};
	always #50 clock = ~clock;
	host_model #(.DLY(DLY)) host_u (.clock(clock), .busy(busy), .req(req));
	system_tools_control_status #(
		.SOFT_RESET_COUNT(20), .RESTORE_COUNT(20), .LOT_LOW_VALUE(LOT_LO),
		.LOT_HIGH_VALUE(LOT_HI), .PRODUCT_VALUE(PROD), .SERIAL_VALUE(SER)
	) dut_u (
		.clock(clock), .rst(rst), .req(req), .rdata(rdata), .busy(busy),
		.sample_tick(sample_tick), .data_fresh(data_fresh),
		.fault_now(fault_now), .selftest_fail(selftest_fail),
		.checksum_bad(checksum_bad), .alarm_control(alarm_control),
		.alarm_active(alarm_active),
		.flash_write_done(flash_write_done), .aux_in(aux_in),
		.aux_out(aux_out), .aux_oe_n(aux_oe_n),
		.soft_reset_pulse(pulses[6]), .backup_start(pulses[5]),
		.restore_start(pulses[4]), .autonull_start(pulses[3]),
		.clear_buffers(pulses[2]), .selftest_start(pulses[1]),
		.memtest_start(pulses[0]), .gyro_lin_comp(gyro_lin_comp),
		.accel_align(accel_align)
	);
	task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		if (err_total == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic rd(input logic [6:0] a, input logic [15:0] e,
		input logic [15:0] m);
		exp_q.push_back(e);
		mask_q.push_back(m);
		host_u.access(a, 16'h0000, 1'b0);
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		host_u.access(a, d, 1'b1);
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge clock);
		#DLY;
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 200) begin
			cycles(1);
			n++;
		end
		check_word({15'h0, busy}, 16'h0000);
	endtask
	always @(posedge clock) begin
		if (rd_seen) begin
			m_exp = exp_q.size() ? exp_q.pop_front() : 16'hDEAD;
			m_mask = mask_q.size() ? mask_q.pop_front() : 16'hFFFF;
			check_word(rdata & m_mask, m_exp & m_mask);
		end
		rd_seen <= req.rd;
	end
	initial begin
		#2000000;
		err_total++;
		end_of_test();
	end
	initial begin
		rnd = 16'($random(seed));
		cycles(20);
		rst = 1'b0;
		for (int i = 0; i < 7; i++) begin
			rd(addr_t[i], val_t[i], 16'hFFFF);
		end
		rd(7'h3C, 16'h0000, 16'hFFFF);
		repeat (3) begin
			flash_write_done = 1'b1;
			cycles(1);
			flash_write_done = 1'b0;
			cycles(1);
		end
		rd(7'h00, 16'h0003, 16'hFFFF);
		data_fresh = 1'b1;
		cycles(3);
		check_word({12'h0, aux_out[0], aux_oe_n[0]}, 16'h0002);
		data_fresh = 1'b0;
		// line one asks for a high output, but the ready owner keeps it
		wr(7'h32, 16'h090D);
		aux_in = rnd[3:0];
		cycles(6);
		check_word({12'h0, aux_oe_n}, 16'h0002);
		check_word({14'h0, aux_out[3:2]}, 16'h0002);
		check_word({15'h0, aux_out[0]}, 16'h0000);
		rd(7'h32, 16'h090D | {6'h0, rnd[1], 9'h0}, 16'hFEFF);
		wr(7'h34, 16'h00C6);
		cycles(1);
		check_word({14'h0, gyro_lin_comp, accel_align}, 16'h0003);
		wr(7'h34, 16'h0004);
		cycles(3);
		check_word({15'h0, aux_out[0]}, 16'h0001);
		data_fresh = 1'b1;
		// alarm indicator on line two, active low, alarm one raised
		alarm_control = 8'h05;
		alarm_active = 2'h1;
		wr(7'h34, 16'h0007);
		cycles(3);
		check_word({14'h0, aux_out[1], aux_oe_n[1]}, 16'h0002);
		wr(7'h34, 16'h0000);
		cycles(3);
		check_word({8'h0, aux_oe_n, aux_out}, 16'h0009);
		alarm_control = 8'h00;
		alarm_active = 2'h0;
		cycles(2);
		check_word({8'h0, aux_oe_n, aux_out}, 16'h0029);
		wr(7'h34, 16'h0406);
		check_word({9'h0, pulses}, 16'h0002);
		wait_idle();
		rd(7'h34, 16'h0006, 16'hFFFF);
		wr(7'h34, 16'h0806);
		check_word({9'h0, pulses}, 16'h0001);
		wait_idle();
		rd(7'h34, 16'h0006, 16'hFFFF);
		for (int i = 0; i < 4; i++) begin
			wr(7'h3E, 16'h0001 << cmd_bit[i]);
			check_word({9'h0, pulses}, 16'h0001 << cmd_pulse[i]);
			wait_idle();
		end
		wr(7'h3E, 16'h0080);
		check_word({8'h0, pulses, busy}, 16'h0081);
		cycles(17);
		check_word({15'h0, busy}, 16'h0001);
		cycles(5);
		check_word({15'h0, busy}, 16'h0000);
		rnd = 16'($random(seed));
		fault_now = {9'h0, rnd[3:0] | 4'h1};
		selftest_fail = rnd[9:4];
		checksum_bad = rnd[10];
		diag_exp = {rnd[9:4], 3'h0, rnd[10], rnd[3:0] | 4'h1, 2'h0};
		sample_tick = 1'b1;
		cycles(1);
		sample_tick = 1'b0;
		rd(7'h3C, diag_exp, 16'hFFFF);
		rd(7'h3C, 16'h0000, 16'hFFFF);
		sample_tick = 1'b1;
		cycles(1);
		sample_tick = 1'b0;
		rd(7'h3C, diag_exp, 16'hFFFF);
		cycles(3);
		end_of_test();
	end
endmodule // test_system_tools_control_status
